// ===== logic/dtpb_top.sv
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "dtpb_cfg.svh"

module dtpb_top
   import dtpb_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // Avalon-MM slave
   input wire logic [5:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Pins and pin option straps
   input wire logic i_ext_clk_in,
   input wire logic i_low_osc,
   input wire logic i_cfg_pin_pwm,
   input wire logic i_cfg_pin_buzzer,
   // Shared output pin
   output logic o_pin_out,
   output logic o_pin_oe,
   // Interrupt request to the core
   output logic o_irq_req
);

   // Edge of a synchronised level, polarity chosen by fall
   function automatic logic edge_hit(input logic cur, input logic prev, input logic fall);
      return fall ? (prev & ~cur) : (cur & ~prev);
   endfunction : edge_hit

   // Low n bits of a divider counter all ones
   function automatic logic div_hit(input logic [7:0] cnt, input logic [3:0] n);
      logic [8:0] m;
      m = (9'h001 << n) - 9'h001;
      return (cnt & m[7:0]) == m[7:0];
   endfunction : div_hit

   // Word-aligned register select
   function automatic logic reg_is(input logic [5:0] a, input logic [5:0] off);
      return a[5:2] == off[5:2];
   endfunction : reg_is

   // Bus state and outputs
   dtpb_bus_st_t bus_st_ff; // Handshake phase
   logic waitreq_ff; // Low only in the ack cycle
   logic [31:0] rdata_ff; // Captured read data
   logic wr_fire; // Write takes effect
   logic [31:0] rd_mux; // Read selection

   // Register state
   dtpb_t0_ctrl_t t0c_ff;
   dtpb_t1_ctrl1_t t1c1_ff;
   dtpb_t1_ctrl2_t t1c2_ff;
   dtpb_buzz_t bz_ctl_ff;
   logic [7:0] duty_ff;
   logic [7:0] reload_ff;
   logic t0_ie_ff;
   logic t1_ie_ff;
   logic gie_ff;
   logic t0_flag_ff;
   logic t1_flag_ff;

   // Counters
   logic [7:0] t0_cnt_ff;
   logic [7:0] ps0_ff;
   logic [7:0] t1_cnt_ff;
   logic [7:0] ps1_ff;
   logic [7:0] bz_cnt_ff;
   logic bz_ff;

   // Synchronisers and edge history
   logic [1:0] ext_sync_ff;
   logic [1:0] losc_sync_ff;
   logic ext_prev_ff;
   logic losc_prev_ff;

   // Output flops
   logic pin_out_ff;
   logic pin_oe_ff;
   logic irq_ff;

   // Combinational events
   logic t0_src_tick;
   logic t0_tick;
   logic t0_ovf;
   logic t1_src_tick;
   logic ps1_out;
   logic t1_tick;
   logic t1_uf;
   logic pwm_level;
   logic bz_src;

   assign o_avs_readdata = rdata_ff;
   assign o_avs_waitrequest = waitreq_ff;
   assign o_pin_out = pin_out_ff;
   assign o_pin_oe = pin_oe_ff;
   assign o_irq_req = irq_ff;

   // Writes land on the edge the master sees waitrequest low
   assign wr_fire = i_avs_write & (bus_st_ff == DTPB_BUS_ACK);

   // One wait cycle per access; the ack cycle never re-arms
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         bus_st_ff <= DTPB_BUS_IDLE;
         waitreq_ff <= 1'b1;
      end else if (bus_st_ff == DTPB_BUS_IDLE && (i_avs_read || i_avs_write)) begin
         bus_st_ff <= DTPB_BUS_ACK;
         waitreq_ff <= 1'b0;
      end else begin
         bus_st_ff <= DTPB_BUS_IDLE;
         waitreq_ff <= 1'b1;
      end
   end

   // Read mux; unmapped words read as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (reg_is(i_avs_address, `DTPB_OFF_TMR0)) begin
         rd_mux[7:0] = t0_cnt_ff;
      end else if (reg_is(i_avs_address, `DTPB_OFF_T0CTRL)) begin
         rd_mux[7:0] = t0c_ff;
      end else if (reg_is(i_avs_address, `DTPB_OFF_TMR1)) begin
         rd_mux[7:0] = t1_cnt_ff;
      end else if (reg_is(i_avs_address, `DTPB_OFF_T1CTRL1)) begin
         rd_mux[7:0] = t1c1_ff;
      end else if (reg_is(i_avs_address, `DTPB_OFF_T1CTRL2)) begin
         rd_mux[7:0] = t1c2_ff;
      end else if (reg_is(i_avs_address, `DTPB_OFF_DUTY)) begin
         rd_mux[7:0] = duty_ff;
      end else if (reg_is(i_avs_address, `DTPB_OFF_PS1VAL)) begin
         rd_mux[7:0] = ps1_ff;
      end else if (reg_is(i_avs_address, `DTPB_OFF_BUZZ)) begin
         rd_mux[7:0] = bz_ctl_ff;
      end else if (reg_is(i_avs_address, `DTPB_OFF_INT)) begin
         rd_mux[`DTPB_INT_T0F] = t0_flag_ff;
         rd_mux[`DTPB_INT_T1F] = t1_flag_ff;
         rd_mux[`DTPB_INT_TIMER0_OVERFLOW_INT_EN] = t0_ie_ff;
         rd_mux[`DTPB_INT_TIMER1_UNDERFLOW_INT_EN] = t1_ie_ff;
         rd_mux[`DTPB_INT_GIE] = gie_ff;
      end
   end

   // Read data captured at request, held through the ack edge
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (bus_st_ff == DTPB_BUS_IDLE && i_avs_read) begin
         rdata_ff <= rd_mux;
      end
   end

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         ext_sync_ff <= 2'h0;
         losc_sync_ff <= 2'h0;
         ext_prev_ff <= 1'b0;
         losc_prev_ff <= 1'b0;
      end else begin
         ext_sync_ff <= {ext_sync_ff[0], i_ext_clk_in};
         losc_sync_ff <= {losc_sync_ff[0], i_low_osc};
         ext_prev_ff <= ext_sync_ff[1];
         losc_prev_ff <= losc_sync_ff[1];
      end
   end

   // Control registers; reserved bits stay zero
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         t0c_ff <= `DTPB_RST_BYTE;
         t1c2_ff <= `DTPB_RST_T1CTRL2;
         duty_ff <= `DTPB_RST_BYTE;
         bz_ctl_ff <= `DTPB_RST_BYTE;
         t0_ie_ff <= 1'b0;
         t1_ie_ff <= 1'b0;
         gie_ff <= 1'b0;
      end else if (wr_fire) begin
         if (reg_is(i_avs_address, `DTPB_OFF_T0CTRL)) begin
            t0c_ff <= i_avs_writedata[7:0];
         end
         if (reg_is(i_avs_address, `DTPB_OFF_T1CTRL2)) begin
            t1c2_ff <= {2'b00, i_avs_writedata[5:0]};
         end
         if (reg_is(i_avs_address, `DTPB_OFF_DUTY)) begin
            duty_ff <= i_avs_writedata[7:0];
         end
         if (reg_is(i_avs_address, `DTPB_OFF_BUZZ)) begin
            bz_ctl_ff <= {i_avs_writedata[7], 3'b000, i_avs_writedata[3:0]};
         end
         if (reg_is(i_avs_address, `DTPB_OFF_INT)) begin
            t0_ie_ff <= i_avs_writedata[`DTPB_INT_TIMER0_OVERFLOW_INT_EN];
            t1_ie_ff <= i_avs_writedata[`DTPB_INT_TIMER1_UNDERFLOW_INT_EN];
            gie_ff <= i_avs_writedata[`DTPB_INT_GIE];
         end
      end
   end

   // Up-counter source: system clock, or edge of external pin or low oscillator
   always_comb begin
      if (!t0c_ff.timer0_source_select) begin
         t0_src_tick = 1'b1;
      end else if (t0c_ff.low_clock_select) begin
         t0_src_tick = edge_hit(losc_sync_ff[1], losc_prev_ff, t0c_ff.timer0_edge_select);
      end else begin
         t0_src_tick = edge_hit(ext_sync_ff[1], ext_prev_ff, t0c_ff.timer0_edge_select);
      end
   end

   // Prescaler0 bypassed when assigned away from the up-counter
   assign t0_tick = t0c_ff.timer0_enable & t0_src_tick &
                    (t0c_ff.prescaler0_assign |
                     div_hit(ps0_ff, {1'b0, t0c_ff.prescaler0_ratio} + 4'h1));
   assign t0_ovf = t0_tick & (t0_cnt_ff == `DTPB_T0_FULL) &
                   ~(wr_fire & reg_is(i_avs_address, `DTPB_OFF_TMR0));

   // Prescaler0 clears on any T0CTRL write that leaves it with the up-counter
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         ps0_ff <= `DTPB_RST_BYTE;
      end else if (wr_fire && reg_is(i_avs_address, `DTPB_OFF_T0CTRL) && !i_avs_writedata[4]) begin
         ps0_ff <= `DTPB_RST_BYTE;
      end else if (t0c_ff.timer0_enable && t0_src_tick && !t0c_ff.prescaler0_assign) begin
         ps0_ff <= ps0_ff + 8'h01;
      end
   end

   // Up-counter; a software load beats a tick in the same cycle
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         t0_cnt_ff <= `DTPB_RST_BYTE;
      end else if (wr_fire && reg_is(i_avs_address, `DTPB_OFF_TMR0)) begin
         t0_cnt_ff <= i_avs_writedata[7:0];
      end else if (t0_tick) begin
         t0_cnt_ff <= t0_cnt_ff + 8'h01;
      end
   end

   // Down-counter source and prescaler1 output
   assign t1_src_tick = t1c2_ff.timer1_source_select ?
                        edge_hit(ext_sync_ff[1], ext_prev_ff, t1c2_ff.timer1_edge_select) : 1'b1;
   assign ps1_out = t1c1_ff.timer1_enable & ~t1c2_ff.prescaler1_disable_n & t1_src_tick &
                    div_hit(ps1_ff, {1'b0, t1c2_ff.prescaler1_ratio} + 4'h1);
   assign t1_tick = t1c1_ff.timer1_enable &
                    (t1c2_ff.prescaler1_disable_n ? t1_src_tick : ps1_out);
   assign t1_uf = t1_tick & (t1_cnt_ff == 8'h00) &
                  ~(wr_fire & reg_is(i_avs_address, `DTPB_OFF_TMR1));

   // Prescaler1 runs only while enabled and the timer runs
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         ps1_ff <= `DTPB_RST_BYTE;
      end else if (t1c1_ff.timer1_enable && !t1c2_ff.prescaler1_disable_n && t1_src_tick) begin
         ps1_ff <= ps1_ff + 8'h01;
      end
   end

   // Mode byte; one-shot underflow drops the enable
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         t1c1_ff <= `DTPB_RST_BYTE;
      end else if (wr_fire && reg_is(i_avs_address, `DTPB_OFF_T1CTRL1)) begin
         t1c1_ff <= {i_avs_writedata[7:6], 3'b000, i_avs_writedata[2:0]};
      end else if (t1_uf && t1c1_ff.timer1_oneshot) begin
         t1c1_ff.timer1_enable <= 1'b0;
      end
   end

   // Down-counter and reload value
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         t1_cnt_ff <= `DTPB_RST_BYTE;
         reload_ff <= `DTPB_RST_BYTE;
      end else if (wr_fire && reg_is(i_avs_address, `DTPB_OFF_TMR1)) begin
         t1_cnt_ff <= i_avs_writedata[7:0];
         reload_ff <= i_avs_writedata[7:0];
      end else if (t1_uf) begin
         if (t1c1_ff.timer1_oneshot) begin
            t1_cnt_ff <= 8'h00;
         end else if (t1c1_ff.timer1_reload_select) begin
            t1_cnt_ff <= reload_ff;
         end else begin
            t1_cnt_ff <= `DTPB_T1_FULL;
         end
      end else if (t1_tick) begin
         t1_cnt_ff <= t1_cnt_ff - 8'h01;
      end
   end

   // Sticky flags; hardware set wins over a software clear
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         t0_flag_ff <= 1'b0;
         t1_flag_ff <= 1'b0;
      end else begin
         if (t0_ovf) begin
            t0_flag_ff <= 1'b1;
         end else if (wr_fire && reg_is(i_avs_address, `DTPB_OFF_INT) && !i_avs_writedata[`DTPB_INT_T0F]) begin
            t0_flag_ff <= 1'b0;
         end
         if (t1_uf) begin
            t1_flag_ff <= 1'b1;
         end else if (wr_fire && reg_is(i_avs_address, `DTPB_OFF_INT) && !i_avs_writedata[`DTPB_INT_T1F]) begin
            t1_flag_ff <= 1'b0;
         end
      end
   end

   // Request level to the core, gated by the master enable
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= gie_ff & ((t0_flag_ff & t0_ie_ff) | (t1_flag_ff & t1_ie_ff));
      end
   end

   // Duty 0 never active; duty N active for N counter clocks
   assign pwm_level = t1c1_ff.timer1_enable & (t1_cnt_ff < duty_ff);

   // Buzzer source: prescaler1 output or down-counter underflow
   assign bz_src = bz_ctl_ff.buzzer_freq_select[3] ? t1_uf : ps1_out;

   // Buzzer divider; toggling halves again, so 2..256 overall
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         bz_cnt_ff <= `DTPB_RST_BYTE;
         bz_ff <= 1'b0;
      end else if (!bz_ctl_ff.buzzer_enable) begin
         bz_cnt_ff <= `DTPB_RST_BYTE;
         bz_ff <= 1'b0;
      end else if (bz_src) begin
         bz_cnt_ff <= bz_cnt_ff + 8'h01;
         if (div_hit(bz_cnt_ff, {1'b0, bz_ctl_ff.buzzer_freq_select[2:0]})) begin
            bz_ff <= ~bz_ff;
         end
      end
   end

   // Shared pin; PWM has priority if both options are set
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         pin_out_ff <= 1'b0;
         pin_oe_ff <= 1'b0;
      end else if (t1c1_ff.pwm_output_enable && i_cfg_pin_pwm) begin
         pin_out_ff <= pwm_level ^ t1c1_ff.pwm_active_low;
         pin_oe_ff <= 1'b1;
      end else if (bz_ctl_ff.buzzer_enable && i_cfg_pin_buzzer) begin
         pin_out_ff <= bz_ff;
         pin_oe_ff <= 1'b1;
      end else begin
         pin_out_ff <= 1'b0;
         pin_oe_ff <= 1'b0;
      end
   end

endmodule : dtpb_top

// ===== logic/dtpb_cfg.svh
`ifndef DTPB_CFG_SVH
`define DTPB_CFG_SVH

// Register byte offsets
`define DTPB_OFF_TMR0 6'h00
`define DTPB_OFF_T0CTRL 6'h04
`define DTPB_OFF_TMR1 6'h08
`define DTPB_OFF_T1CTRL1 6'h0C
`define DTPB_OFF_T1CTRL2 6'h10
`define DTPB_OFF_DUTY 6'h14
`define DTPB_OFF_PS1VAL 6'h18
`define DTPB_OFF_BUZZ 6'h1C
`define DTPB_OFF_INT 6'h20

// Interrupt register field positions
`define DTPB_INT_T0F 0
`define DTPB_INT_T1F 3
`define DTPB_INT_TIMER0_OVERFLOW_INT_EN 8
`define DTPB_INT_TIMER1_UNDERFLOW_INT_EN 11
`define DTPB_INT_GIE 15

// Reset values and full counts
`define DTPB_RST_BYTE 8'h00
`define DTPB_RST_T1CTRL2 8'h08
`define DTPB_T1_FULL 8'hFF
`define DTPB_T0_FULL 8'hFF

`endif

// ===== logic/dtpb_pkg.sv
package dtpb_pkg;

   // Bus slave handshake state
   typedef enum logic {DTPB_BUS_IDLE, DTPB_BUS_ACK} dtpb_bus_st_t;

   // Up-counter control byte
   typedef struct packed {
      logic low_clock_select;
      logic timer0_source_select;
      logic timer0_edge_select;
      logic prescaler0_assign;
      logic [2:0] prescaler0_ratio;
      logic timer0_enable;
   } dtpb_t0_ctrl_t;

   // Down-counter mode and PWM byte
   typedef struct packed {
      logic pwm_output_enable;
      logic pwm_active_low;
      logic [2:0] rsvd;
      logic timer1_oneshot;
      logic timer1_reload_select;
      logic timer1_enable;
   } dtpb_t1_ctrl1_t;

   // Down-counter source and prescaler byte
   typedef struct packed {
      logic [1:0] rsvd;
      logic timer1_source_select;
      logic timer1_edge_select;
      logic prescaler1_disable_n;
      logic [2:0] prescaler1_ratio;
   } dtpb_t1_ctrl2_t;

   // Buzzer control byte
   typedef struct packed {
      logic buzzer_enable;
      logic [2:0] rsvd;
      logic [3:0] buzzer_freq_select;
   } dtpb_buzz_t;

endpackage : dtpb_pkg

// ===== test/dtpb_properties.sv
`timescale 1ns/1ns
module dtpb_chk (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // Register bus
   input wire logic [5:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   // Pin straps and outputs
   input wire logic i_cfg_pin_pwm,
   input wire logic i_cfg_pin_buzzer,
   input wire logic o_pin_oe,
   input wire logic o_irq_req
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_srst);

   // Accepted write, the only moment a shadowed enable changes
   wire logic wr_ack = i_avs_write && !o_avs_waitrequest;
   logic gie_ff; // Shadow of the global enable
   logic ien_ff; // Any timer interrupt enable
   logic pwm_ff; // Shadow of the PWM output enable
   logic buz_ff; // Shadow of the buzzer enable

   // Interrupt enable shadows
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         gie_ff <= 1'h0;
         ien_ff <= 1'h0;
      end else if (wr_ack && i_avs_address[5:2] == 4'h8) begin
         gie_ff <= i_avs_writedata[15];
         ien_ff <= i_avs_writedata[8] | i_avs_writedata[11];
      end
   end

   // Pin enable shadows; straps are combined in the properties
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         pwm_ff <= 1'h0;
         buz_ff <= 1'h0;
      end else if (wr_ack && i_avs_address[5:2] == 4'h3) begin
         pwm_ff <= i_avs_writedata[7];
      end else if (wr_ack && i_avs_address[5:2] == 4'h7) begin
         buz_ff <= i_avs_writedata[7];
      end
   end

   // Handshake steps
   sequence s_taken;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence s_ack;
      !o_avs_waitrequest ##1 o_avs_waitrequest;
   endsequence

   chk_bus_ack_once: assert property (s_taken |=> s_ack)
      else $error("bus request not answered in one cycle");
   chk_ack_has_cause: assert property ($fell(o_avs_waitrequest) |-> $past(i_avs_read || i_avs_write))
      else $error("bus answer without request");
   chk_rdata_hold: assert property ($changed(o_avs_readdata) |-> $past(i_avs_read && o_avs_waitrequest))
      else $error("read data moved outside a read");
   chk_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address[5:2] > 4'h8
      |-> o_avs_readdata == 32'h0) else $error("unmapped read not zero");
   chk_upper_bits_zero: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address[5:2] != 4'h8
      |-> o_avs_readdata[31:8] == 24'h0) else $error("unused read bits set");
   chk_irq_global_gate: assert property (o_irq_req |-> $past(gie_ff))
      else $error("interrupt without global enable");
   chk_irq_source_en: assert property (o_irq_req |-> $past(ien_ff))
      else $error("interrupt without source enable");
   chk_oe_has_cause: assert property (o_pin_oe |-> $past(pwm_ff && i_cfg_pin_pwm || buz_ff && i_cfg_pin_buzzer))
      else $error("pin driven without enable");
   chk_oe_follows_en: assert property (pwm_ff && i_cfg_pin_pwm ##1 pwm_ff && i_cfg_pin_pwm |-> o_pin_oe)
      else $error("PWM pin not forced to output");
endmodule : dtpb_chk

// ===== test/dtpb_top_tb.sv
`timescale 1ns/1ns
`include "dtpb_cfg.svh"
module dtpb_top_tb;
   logic i_clk_sys = 1'h0;
   logic i_srst = 1'h1;
   logic [5:0] i_avs_address = 6'h00;
   logic i_avs_read = 1'h0, i_avs_write = 1'h0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic i_ext_clk_in = 1'h0, i_low_osc = 1'h0, i_cfg_pin_pwm = 1'h0, i_cfg_pin_buzzer = 1'h0;
   logic [31:0] o_avs_readdata;
   logic o_avs_waitrequest, o_pin_out, o_pin_oe, o_irq_req;
   int errors = 0, cmp_count = 0;
   logic [31:0] rd; // Last read word

   dtpb_top dtpb_top_inst (.i_clk_sys, .i_srst, .i_avs_address, .i_avs_read, .i_avs_write,
      .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_ext_clk_in, .i_low_osc,
      .i_cfg_pin_pwm, .i_cfg_pin_buzzer, .o_pin_out, .o_pin_oe, .o_irq_req);

   // 100 MHz clock
   always #5 i_clk_sys = ~i_clk_sys;

   task automatic test_done();
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // One bus access; held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clk_sys);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_read <= !wr;
      i_avs_write <= wr;
      for (n = 0; n < 20; n++) begin
         @(posedge i_clk_sys);
         if (o_avs_waitrequest === 1'h0) break;
      end
      if (n == 20) begin
         errors++;
         test_done();
      end
      rd = o_avs_readdata;
      i_avs_read <= 1'h0;
      i_avs_write <= 1'h0;
   endtask : bus

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
   endtask : wr

   task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      check(rd, e);
   endtask : rdchk

   task automatic waitn(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask : waitn

   // Toggle the external pin or low oscillator k times, slower than the clock
   task automatic tog(input logic lo, input int k);
      repeat (k) begin
         waitn(4);
         if (lo) i_low_osc <= !i_low_osc;
         else i_ext_clk_in <= !i_ext_clk_in;
      end
      waitn(8);
   endtask : tog

   task automatic t_reset();
      check({o_pin_oe, o_irq_req}, 32'h0);
      rdchk(`DTPB_OFF_T1CTRL2, 32'h8);
      rdchk(`DTPB_OFF_TMR0, 32'h0);
      wr(6'h24, 32'hFF);
      rdchk(6'h24, 32'h0);
   endtask : t_reset

   // Every prescaler ratio over a fixed 256-cycle run
   task automatic t0_presc();
      int r;
      for (r = 0; r < 8; r++) begin
         wr(`DTPB_OFF_TMR0, 32'h0);
         wr(`DTPB_OFF_T0CTRL, 32'(r * 2 + 1));
         waitn(256);
         wr(`DTPB_OFF_T0CTRL, 32'(r * 2));
         bus(1'h0, `DTPB_OFF_TMR0, 32'h0);
         check(rd + 2 >= (256 >> (r + 1)) && rd <= (256 >> (r + 1)) + 2, 32'h1);
      end
   endtask : t0_presc

   task automatic t0_flag();
      wr(`DTPB_OFF_TMR0, 32'hFE);
      wr(`DTPB_OFF_T0CTRL, 32'h11);
      waitn(8);
      wr(`DTPB_OFF_T0CTRL, 32'h10);
      rdchk(`DTPB_OFF_INT, 32'h1);
      wr(`DTPB_OFF_INT, 32'h8101);
      waitn(3);
      check(o_irq_req, 32'h1);
      wr(`DTPB_OFF_INT, 32'h0101);
      waitn(3);
      check(o_irq_req, 32'h0);
      wr(`DTPB_OFF_INT, 32'h8100);
      waitn(3);
      check(o_irq_req, 32'h0);
      rdchk(`DTPB_OFF_INT, 32'h8100);
      wr(`DTPB_OFF_INT, 32'h0);
   endtask : t0_flag

   // Pin sources; odd toggle counts tell the two edges apart
   task automatic t0_pins();
      wr(`DTPB_OFF_T0CTRL, 32'h51);
      wr(`DTPB_OFF_TMR0, 32'h0);
      tog(1'h0, 5);
      rdchk(`DTPB_OFF_TMR0, 32'h3);
      wr(`DTPB_OFF_T0CTRL, 32'h71);
      wr(`DTPB_OFF_TMR0, 32'h0);
      tog(1'h0, 3);
      rdchk(`DTPB_OFF_TMR0, 32'h2);
      // Low oscillator only feeds the count; the core keeps the system clock
      wr(`DTPB_OFF_T0CTRL, 32'hD1);
      wr(`DTPB_OFF_TMR0, 32'h0);
      tog(1'h1, 4);
      rdchk(`DTPB_OFF_TMR0, 32'h2);
      wr(`DTPB_OFF_T0CTRL, 32'h50);
      wr(`DTPB_OFF_TMR0, 32'h0);
      tog(1'h0, 2);
      rdchk(`DTPB_OFF_TMR0, 32'h0);
   endtask : t0_pins

   task automatic t1_modes();
      logic [31:0] t1v; // Down-count seen before the prescaler read
      wr(`DTPB_OFF_TMR1, 32'h5);
      waitn(10);
      rdchk(`DTPB_OFF_TMR1, 32'h5);
      wr(`DTPB_OFF_T1CTRL1, 32'h5);
      waitn(20);
      rdchk(`DTPB_OFF_TMR1, 32'h0);
      rdchk(`DTPB_OFF_INT, 32'h8);
      wr(`DTPB_OFF_INT, 32'h0);
      wr(`DTPB_OFF_TMR1, 32'h2);
      wr(`DTPB_OFF_T1CTRL1, 32'h1);
      waitn(4);
      wr(`DTPB_OFF_T1CTRL1, 32'h0);
      bus(1'h0, `DTPB_OFF_TMR1, 32'h0);
      check(rd > 32'hF0 && rd < 32'h100, 32'h1);
      wr(`DTPB_OFF_TMR1, 32'h2);
      wr(`DTPB_OFF_T1CTRL1, 32'h3);
      waitn(20);
      wr(`DTPB_OFF_T1CTRL1, 32'h0);
      bus(1'h0, `DTPB_OFF_TMR1, 32'h0);
      check(rd < 32'h3, 32'h1);
      // Prescaler at divide by 8
      wr(`DTPB_OFF_T1CTRL2, 32'h2);
      wr(`DTPB_OFF_TMR1, 32'hFF);
      wr(`DTPB_OFF_T1CTRL1, 32'h1);
      waitn(80);
      wr(`DTPB_OFF_T1CTRL1, 32'h0);
      bus(1'h0, `DTPB_OFF_TMR1, 32'h0);
      check(rd >= 32'hF3 && rd <= 32'hF7, 32'h1);
      t1v = rd;
      bus(1'h0, `DTPB_OFF_PS1VAL, 32'h0);
      // Prescaler starts from zero here, so each eight of its counts is one step
      check(rd >> 3, 32'hFF - t1v);
      // External pin, rising then falling edges
      wr(`DTPB_OFF_T1CTRL2, 32'h28);
      wr(`DTPB_OFF_TMR1, 32'h10);
      wr(`DTPB_OFF_T1CTRL1, 32'h1);
      tog(1'h0, 3);
      rdchk(`DTPB_OFF_TMR1, 32'hE);
      wr(`DTPB_OFF_T1CTRL2, 32'h38);
      wr(`DTPB_OFF_TMR1, 32'h10);
      tog(1'h0, 3);
      rdchk(`DTPB_OFF_TMR1, 32'hE);
      wr(`DTPB_OFF_T1CTRL1, 32'h0);
      wr(`DTPB_OFF_T1CTRL2, 32'h8);
   endtask : t1_modes

   // Eight-count frame; active cycles counted over ten frames
   task automatic pwm_run(input logic [31:0] ctl, input logic [31:0] duty, input int lo, input int hi);
      int n;
      // Every caller keeps duty at or below the initial count of 7
      wr(`DTPB_OFF_DUTY, duty);
      wr(`DTPB_OFF_TMR1, 32'h7);
      wr(`DTPB_OFF_T1CTRL1, ctl);
      waitn(8);
      n = 0;
      repeat (80) begin
         @(posedge i_clk_sys);
         n += (o_pin_out ^ ctl[6]);
      end
      check(o_pin_oe, 32'h1);
      check(n >= lo && n <= hi, 32'h1);
      wr(`DTPB_OFF_T1CTRL1, 32'h0);
      waitn(3);
      check(o_pin_oe, 32'h0);
   endtask : pwm_run

   // Toggles of the buzzer over 80 cycles
   task automatic buzz_run(input logic [31:0] t2, input logic [31:0] bz, input int lo, input int hi);
      int n;
      logic p;
      wr(`DTPB_OFF_T1CTRL2, t2);
      wr(`DTPB_OFF_BUZZ, bz);
      wr(`DTPB_OFF_TMR1, 32'h3);
      wr(`DTPB_OFF_T1CTRL1, 32'h3);
      waitn(8);
      p = o_pin_out;
      n = 0;
      repeat (80) begin
         @(posedge i_clk_sys);
         n += (o_pin_out !== p);
         p = o_pin_out;
      end
      check(o_pin_oe, 32'h1);
      check(n >= lo && n <= hi, 32'h1);
      wr(`DTPB_OFF_T1CTRL1, 32'h0);
      wr(`DTPB_OFF_BUZZ, 32'h0);
   endtask : buzz_run

   // Main sequence
   initial begin
      waitn(20);
      check(o_avs_waitrequest, 32'h1);
      i_srst <= 1'h0;
      waitn(2);
      t_reset();
      t0_presc();
      t0_flag();
      t0_pins();
      t1_modes();
      i_cfg_pin_pwm <= 1'h1;
      pwm_run(32'h83, 32'h2, 18, 22);
      pwm_run(32'hC3, 32'h2, 18, 22);
      pwm_run(32'hC3, 32'h0, 0, 0);
      pwm_run(32'h83, 32'h7, 68, 72);
      i_cfg_pin_pwm <= 1'h0;
      i_cfg_pin_buzzer <= 1'h1;
      buzz_run(32'h8, 32'h88, 19, 21);
      buzz_run(32'h8, 32'h89, 9, 11);
      buzz_run(32'h0, 32'h80, 39, 41);
      test_done();
   end
endmodule : dtpb_top_tb

bind dtpb_top dtpb_chk dtpb_chk_inst (.i_clk_sys, .i_srst, .i_avs_address, .i_avs_read, .i_avs_write,
   .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_cfg_pin_pwm, .i_cfg_pin_buzzer,
   .o_pin_oe, .o_irq_req);
